// >>> hw/rid_pkg.sv
// Package: register map, field positions, reset values and timing for the reference input divider
package rid_pkg;
  localparam int unsigned      DATA_W            = 32;
  localparam int unsigned      ADDR_W            = 8;
  localparam int unsigned      RATIO_W           = 20;
  localparam int unsigned      NUM_INPUTS        = 4;
  localparam logic [7:0]       CFG_OFFSET        = 8'h00;
  localparam logic [7:0]       STATUS_OFFSET     = 8'h10;
  localparam logic [7:0]       SELECT_OFFSET     = 8'h14;
  localparam int unsigned      RATIO_LSB         = 0;
  localparam int unsigned      BYPASS_BIT        = 20;
  localparam int unsigned      ENABLE_N_BIT      = 21;
  localparam int unsigned      SET_N_BIT         = 22;
  localparam int unsigned      PRIORITY_BIT      = 24;
  localparam logic [31:0]      CFG_WRITE_MASK    = 32'h017F_FFFF;
  localparam logic [31:0]      CFG_RESET         = 32'h0050_0000;
  localparam logic [19:0]      RATIO_MIN         = 20'h0_0002;
  localparam logic [19:0]      COUNT_START       = 20'h0_0001;
  localparam logic [1:0]       RESP_OKAY         = 2'h0;
  localparam logic [1:0]       RESP_SLVERR       = 2'h2;
  localparam int unsigned      SYNC_STAGES       = 2;
  typedef enum logic [1:0] {
    RID_DIV_HELD = 2'h0,
    RID_DIV_RUN  = 2'h1,
    RID_DIV_BYP  = 2'h3,
    RID_DIV_OFF  = 2'h2
  } rid_div_state_e;
endpackage : rid_pkg

// >>> hw/rid_cfg_if.sv
// Interface: divider configuration carried from the register file to each divider
`timescale 1ns/1ps
`default_nettype none
interface rid_cfg_if;
  logic [19:0] ratio;
  logic        bypass;
  logic        enable_n;
  logic        set_n;
  modport src (output ratio, output bypass, output enable_n, output set_n);
  modport dst (input ratio, input bypass, input enable_n, input set_n);
endinterface : rid_cfg_if
`default_nettype wire

// >>> hw/rid_divider.sv
// Module: one reference input divider sampled on the system clock
`timescale 1ns/1ps
`default_nettype none
module rid_divider
  import rid_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       ref_in,
  rid_cfg_if.dst          cfg,
  output logic            div_out,
  output logic            running
);
  logic [1:0]        sync;
  logic              ref_prev;
  logic [19:0]       count;
  rid_div_state_e    state;
  rid_div_state_e    next_state;
  wire               rise = sync[1] & ~ref_prev;
  wire [19:0]        half = {1'b0, cfg.ratio[19:1]};
  wire               wrap = (count >= cfg.ratio);

  // Running follows the registered state, so status and selection see one settled value
  assign running = (state == RID_DIV_RUN) || (state == RID_DIV_BYP);

  // Config is decoded to a state each cycle; held set takes priority
  always_comb begin
    if (!cfg.set_n) next_state = RID_DIV_HELD;
    else if (cfg.bypass) next_state = RID_DIV_BYP;
    else if (cfg.enable_n) next_state = RID_DIV_OFF;
    else next_state = RID_DIV_RUN;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync     <= 2'h0;
      ref_prev <= 1'b0;
      state    <= RID_DIV_HELD;
      count    <= COUNT_START;
      div_out  <= 1'b0;
    end else begin
      sync     <= {sync[0], ref_in};
      ref_prev <= sync[1];
      state    <= next_state;
      case (next_state)
        RID_DIV_HELD: begin
          count   <= COUNT_START;
          div_out <= 1'b0;
        end
        RID_DIV_BYP: begin
          count   <= COUNT_START;
          div_out <= sync[1];
        end
        RID_DIV_OFF: begin
          div_out <= 1'b0;
        end
        default: begin
          if (rise) begin
            count   <= wrap ? COUNT_START : count + 20'h0_0001;
            div_out <= wrap ? 1'b1 : (count < half) ? div_out : 1'b0;
          end
        end
      endcase
    end
  end
endmodule : rid_divider
`default_nettype wire

// >>> hw/rid_top.sv
// Module: AXI4-Lite configured reference input dividers with priority selection
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module rid_top
  import rid_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic [3:0]           ref_in,
  output logic      [3:0]           div_clk_out,
  output logic      [1:0]           selected_input,
  output logic                      selected_valid,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic      [1:0]           s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic      [31:0]          s_axi_rdata,
  output logic      [1:0]           s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);
  import rid_pkg::*;

  logic [31:0]      cfg_reg [NUM_INPUTS];
  logic [3:0]       running;
  logic [3:0]       div_raw;
  logic             aw_held;
  logic             w_held;
  logic [7:0]       aw_addr;
  logic [31:0]      w_data;
  logic [3:0]       w_strb;

  // Decode of write address: one config word per input; status and select are not writable
  wire  [7:0]       wr_addr  = aw_addr;
  wire              wr_fire  = aw_held & w_held & ~s_axi_bvalid;
  wire              wr_cfg   = (wr_addr[7:4] == 4'h0) && (wr_addr[1:0] == 2'h0);
  wire  [1:0]       wr_idx   = wr_addr[3:2];
  wire  [31:0]      strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire  [31:0]      wr_mask  = strb_mask & CFG_WRITE_MASK;
  wire  [31:0]      wr_merged = (cfg_reg[wr_idx] & ~wr_mask) | (w_data & wr_mask);

  // Read decode
  wire  [7:0]       rd_addr  = s_axi_araddr;
  wire              rd_fire  = s_axi_arvalid & s_axi_arready;
  wire              rd_cfg   = (rd_addr[7:4] == 4'h0) && (rd_addr[1:0] == 2'h0);
  wire              rd_stat  = (rd_addr == STATUS_OFFSET);
  wire              rd_sel   = (rd_addr == SELECT_OFFSET);
  wire  [31:0]      rd_value;
  wire              rd_ok;
  assign rd_value = rd_cfg  ? cfg_reg[rd_addr[3:2]] :
                    rd_stat ? {28'h000_0000, running} :
                    rd_sel  ? {29'h0000_0000, selected_valid, selected_input} : 32'h0000_0000;
  assign rd_ok    = rd_cfg | rd_stat | rd_sel;

  // Priority selection among running inputs: priority bit clear first, then lowest index
  logic [1:0]       next_sel;
  logic             next_sel_valid;
  always_comb begin
    next_sel       = 2'h0;
    next_sel_valid = 1'b0;
    for (int i = NUM_INPUTS - 1; i >= 0; i--) begin
      if (running[i] && !cfg_reg[i][PRIORITY_BIT]) begin
        next_sel       = 2'(i);
        next_sel_valid = 1'b1;
      end
    end
    if (!next_sel_valid) begin
      for (int i = NUM_INPUTS - 1; i >= 0; i--) begin
        if (running[i] && cfg_reg[i][PRIORITY_BIT]) begin
          next_sel       = 2'(i);
          next_sel_valid = 1'b1;
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_INPUTS; g++) begin : gen_div
      rid_cfg_if cfg_bus ();
      assign cfg_bus.ratio    = cfg_reg[g][RATIO_LSB +: RATIO_W];
      assign cfg_bus.bypass   = cfg_reg[g][BYPASS_BIT];
      assign cfg_bus.enable_n = cfg_reg[g][ENABLE_N_BIT];
      assign cfg_bus.set_n    = cfg_reg[g][SET_N_BIT];
      rid_divider u_div (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .ref_in  (ref_in[g]),
        .cfg     (cfg_bus.dst),
        .div_out (div_raw[g]),
        .running (running[g])
      );
    end
  endgenerate

  // Write channel: address and data taken in either order
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_held & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
      s_axi_wready  <= ~w_held & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
    end
  end

  // Ratio below the minimum with bypass clear is software's fault; it is stored but flagged SLVERR
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (!wr_cfg) ? RESP_SLVERR :
                      (!wr_merged[BYPASS_BIT] && wr_merged[19:0] < RATIO_MIN) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_INPUTS; i++) begin
        cfg_reg[i] <= CFG_RESET;
      end
    end else if (wr_fire && wr_cfg) begin
      cfg_reg[wr_idx] <= wr_merged;
    end
  end

  // Read channel: one read in flight
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~rd_fire;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_value;
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_clk_out    <= 4'h0;
      selected_input <= 2'h0;
      selected_valid <= 1'b0;
    end else begin
      div_clk_out    <= div_raw;
      selected_input <= next_sel;
      selected_valid <= next_sel_valid;
    end
  end
endmodule : rid_top
`default_nettype wire

// >>> tb/rid_top_assertions.sv
// Checker: register port handshakes and divider output shape at the top ports
`timescale 1ns/1ps
`default_nettype none
module rid_top_checker
  import rid_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [3:0]  div_clk_out,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Whole-word config write that leaves bypass clear with a ratio below two
  sequence bad_ratio;
    wr_taken ##0 (s_axi_awaddr < 8'h10 && s_axi_wstrb == 4'hF && !s_axi_wdata[20] && s_axi_wdata[19:0] < RATIO_MIN);
  endsequence
  chk_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_write_pending: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  chk_bresp_refuse: assert property (bad_ratio |-> ##2 (s_axi_bvalid && s_axi_bresp == RESP_SLVERR))
    else $error("small ratio not refused");
  chk_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held after handshake");
  chk_read_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read response late");
  chk_read_pending: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  chk_read_unmapped: assert property (rd_taken ##0 s_axi_araddr > 8'h14 |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  // Input 0 stays bypassed; its high phase is four clocks, so a pulse under three clocks means a glitch
  chk_bypass_width: assert property ($rose(div_clk_out[0]) |-> div_clk_out[0] [*3])
    else $error("bypassed output pulse too short");
endmodule : rid_top_checker
bind rid_top rid_top_checker chk (.ref_clk, .rst_n, .div_clk_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid);
`default_nettype wire

// >>> tb/rid_ref_source.sv
// Partner: four free-running reference clocks, one per input
`timescale 1ns/1ps
`default_nettype none
module rid_ref_source (
  output logic [3:0] ref_in
);
  // 12.5 to 7.1 MHz: under 33 MHz so bypass is legal; edges kept 2 ns off ref_clk edges
  initial begin
    ref_in = 4'h0;
    #2;
    fork
      forever #40 ref_in[0] = ~ref_in[0];
      forever #50 ref_in[1] = ~ref_in[1];
      forever #60 ref_in[2] = ~ref_in[2];
      forever #70 ref_in[3] = ~ref_in[3];
    join
  end
endmodule : rid_ref_source
`default_nettype wire

// >>> tb/rid_top_bench.sv
// Bench: drives the divider block over its register port and measures outputs
`timescale 1ns/1ps
`default_nettype none
module rid_top_bench;
  import rid_pkg::*;
  logic        ref_clk = 1'h0;
  logic        rst_n = 1'h0;
  wire  [3:0]  ref_in;
  logic [3:0]  div_clk_out;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  selected_input;
  logic        selected_valid;
  int          err_total = 0, checks = 0;
  always #5 ref_clk = ~ref_clk;
  rid_ref_source src (.ref_in);
  rid_top dut (.ref_clk, .rst_n, .ref_in, .div_clk_out, .selected_input, .selected_valid,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // Ready and valid are judged at the rising edge that moves the item; each channel is released there
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic aw, w, b;
    logic [1:0] r;
    aw = 1'h1;
    w = 1'h1;
    b = 1'h1;
    r = 2'h3;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (aw || w || b) begin
      @(posedge ref_clk);
      if (aw && s_axi_awready) begin
        aw = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (w && s_axi_wready) begin
        w = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
      if (b && s_axi_bvalid) begin
        b = 1'h0;
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
      end
    end
    cmp({30'h0, r}, {30'h0, e});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ar, rv;
    logic [31:0] q;
    logic [1:0] r;
    ar = 1'h1;
    rv = 1'h1;
    q = 32'h0;
    r = 2'h3;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (ar || rv) begin
      @(posedge ref_clk);
      if (ar && s_axi_arready) begin
        ar = 1'h0;
        s_axi_arvalid <= 1'h0;
      end
      if (rv && s_axi_rvalid) begin
        rv = 1'h0;
        q = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
      end
    end
    cmp(q, d);
    cmp({30'h0, r}, {30'h0, e});
  endtask : rd
  // Reference rises between two output rises; pipeline lag cancels out
  task automatic per(input int i, input int exp);
    int n, k;
    logic pr, po;
    n = 0;
    k = 0;
    pr = ref_in[i];
    po = div_clk_out[i];
    while (k < 2) begin
      @(negedge ref_clk);
      if (ref_in[i] && !pr) n++;
      if (div_clk_out[i] && !po) k++;
      if (div_clk_out[i] && !po && k == 1) n = 0;
      pr = ref_in[i];
      po = div_clk_out[i];
    end
    cmp(n, exp);
  endtask : per
  task automatic quiet(input int i);
    logic hi;
    hi = 1'h0;
    repeat (40) begin
      @(negedge ref_clk);
      hi = hi | div_clk_out[i];
    end
    cmp({31'h0, hi}, 32'h0);
  endtask : quiet
  task automatic t_reset;
    rd(CFG_OFFSET, 32'h0050_0000, RESP_OKAY);
    rd(8'h10, 32'h0000_000F, RESP_OKAY);
    rd(8'h14, 32'h0000_0004, RESP_OKAY);
    rd(8'h18, 32'h0, RESP_SLVERR);
    wr(8'h18, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(CFG_OFFSET, 32'hFFFF_FFFF, RESP_OKAY);
    rd(CFG_OFFSET, 32'h017F_FFFF, RESP_OKAY);
    wr(CFG_OFFSET, 32'h0050_0000, RESP_OKAY);
  endtask : t_reset
  task automatic t_divide;
    per(0, 1);
    wr(8'h04, 32'h0040_0003, RESP_OKAY);
    per(1, 3);
    wr(8'h08, 32'h0040_0002, RESP_OKAY);
    per(2, 2);
    wr(8'h0C, 32'h0040_0001, RESP_SLVERR);
    wr(8'h0C, 32'h0050_0000, RESP_OKAY);
  endtask : t_divide
  task automatic t_hold;
    wr(8'h04, 32'h0000_0003, RESP_OKAY);
    rd(8'h10, 32'h0000_000D, RESP_OKAY);
    quiet(1);
    wr(8'h04, 32'h0040_0003, RESP_OKAY);
    per(1, 3);
  endtask : t_hold
  task automatic t_disable;
    wr(8'h08, 32'h0060_0002, RESP_OKAY);
    rd(8'h10, 32'h0000_000B, RESP_OKAY);
    quiet(2);
    wr(8'h08, 32'h0040_0002, RESP_OKAY);
    per(2, 2);
  endtask : t_disable
  task automatic t_priority;
    wr(8'h00, 32'h0150_0000, RESP_OKAY);
    rd(8'h14, 32'h0000_0005, RESP_OKAY);
    cmp({29'h0, selected_valid, selected_input}, 32'h0000_0005);
    wr(8'h04, 32'h0140_0003, RESP_OKAY);
    rd(8'h14, 32'h0000_0006, RESP_OKAY);
    cmp({29'h0, selected_valid, selected_input}, 32'h0000_0006);
    // Only the low byte lane is enabled, so bypass and priority bytes must survive
    s_axi_wstrb <= 4'h1;
    wr(8'h0C, 32'hFFFF_FF07, RESP_OKAY);
    rd(8'h0C, 32'h0050_0007, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
  endtask : t_priority
  task automatic conclude;
    $display("Mismatches %0d, comparisons %0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'h1;
    t_reset();
    t_divide();
    t_hold();
    t_disable();
    t_priority();
    conclude();
  end
  // All scenarios need well under 10 us; a hang is cut at 200 us
  initial begin
    #200000;
    err_total++;
    conclude();
  end
endmodule : rid_top_bench
`default_nettype wire
